// ---- inc/vmon_pkg.sv ----
// Shared constants and carriers of the input-voltage limit monitor.
// Assumes one 125 MHz clock; bus pins are sampled, not clocked from.
package vmon_pkg;
  // --------------------------------------------------------------
  // Timing and voltage scaling
  // --------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int HYST_MV = 250;
  localparam int LSB_UV = 76157;  // 19.42 V spread over 255 codes
  localparam int HYST_CODES = (HYST_MV * 1000 + LSB_UV - 1) / LSB_UV;
  localparam int TICK_US = 1000;
  localparam int STRAP_SETTLE = 3;
  // --------------------------------------------------------------
  // Command codes
  // --------------------------------------------------------------
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_STORE_ADDR = 8'h15;
  localparam logic [7:0] CMD_OV_WARN = 8'h57;
  localparam logic [7:0] CMD_UV_WARN = 8'h58;
  localparam logic [7:0] CMD_UV_FAULT = 8'h59;
  localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
  localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
  localparam logic [7:0] CMD_STATUS_OUT = 8'h7A;
  localparam logic [7:0] CMD_STATUS_INPUT = 8'h7C;
  localparam logic [7:0] CMD_MAKER_TWO = 8'h80;
  localparam logic [7:0] CMD_ALERT_MASK = 8'hDB;
  localparam logic [7:0] CMD_PIN_CONFIG = 8'hE1;
  localparam logic [7:0] CMD_EVENT_READ = 8'hF5;
  localparam logic [7:0] CMD_WRITE_UNLOCK = 8'hF8;
  localparam logic [7:0] CMD_EVENT_TIMER = 8'hFA;
  localparam logic [7:0] CMD_USER_ADDR = 8'hFB;
  // --------------------------------------------------------------
  // Reset values and fields
  // --------------------------------------------------------------
  localparam logic [7:0] OV_WARN_RST = 8'hA5;
  localparam logic [7:0] UV_WARN_RST = 8'h95;
  localparam logic [7:0] UV_FAULT_RST = 8'h8D;
  localparam logic [7:0] PIN_CFG_RST = 8'h03;
  localparam logic [7:0] UNLOCKED = 8'h00;
  localparam logic [6:0] DEFAULT_ADDR = 7'h40;
  localparam logic [1:0] PIN_OPEN = 2'h2;
  localparam int SB_SWITCH_OFF = 6;
  localparam int SB_UV_FAULT = 3;
  localparam int SB_CATCH_ALL = 0;
  localparam int SW_OUT = 7;
  localparam int SW_INPUT = 5;
  localparam int SW_PG_LOW = 3;
  localparam int SW_CATCH_ALL = 1;
  localparam int SI_OV_WARN = 6;
  localparam int SI_UV_WARN = 5;
  localparam int SI_UV_FAULT = 4;
  localparam int SO_UV_WARN = 5;
  localparam int MS2_PG_LOW = 4;
  localparam int MASK_OUT = 7;
  localparam int MASK_IN = 5;
  localparam int MASK_PG = 3;
  localparam int CFG_PG = 0;
  localparam int CFG_ALERT = 1;
  localparam logic [3:0] EV_UV_WARN = 4'h1;
  localparam logic [3:0] EV_OV_WARN = 4'h2;
  localparam logic [2:0] PTR_LAST = 3'h6;

  typedef struct packed {
    logic start;
    logic stop;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic rd_go;
    logic tx_next;
  } smb_evt_s;
endpackage

// ---- src/smb_target.sv ----
// Byte level target of the two-wire management bus.
// Assumes the bus clock is at most clk_i/8, high and low each >= 4 clocks.
`timescale 1ns/1ps
module smb_target
  import vmon_pkg::*;
(
  input wire logic clk_i,  // System clock
  input wire logic srst_i,  // Synchronous reset
  input wire logic scl_i,  // Bus clock pin
  input wire logic sda_i,  // Bus data pin level
  input wire logic [6:0] own_addr_i,  // Address to answer
  input wire logic [7:0] tx_byte_i,  // Next byte to return
  output logic sda_oe_o,  // Pull data low
  output smb_evt_s evt_o  // Bus events, one-cycle pulses
);
  typedef enum logic [2:0] {IDLE, ADDR, ACK_ADDR, RX, ACK_RX, TX, TX_ACK} phase_e;
  typedef struct packed {
    logic scl_m, scl_s, scl_d;
    logic sda_m, sda_s, sda_d;
    phase_e phase;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic oe;
    smb_evt_s evt;
  } tgt_s;
  localparam tgt_s TGT_RST = '{default: '0, scl_m: 1'b1, scl_s: 1'b1, scl_d: 1'b1,
                               sda_m: 1'b1, sda_s: 1'b1, sda_d: 1'b1, phase: IDLE};
  tgt_s s;
  tgt_s n;
  logic rise;
  logic fall;

  always_comb
  begin
    n = s;
    n.evt = '0;
    n.scl_m = scl_i;
    n.scl_s = s.scl_m;
    n.scl_d = s.scl_s;
    n.sda_m = sda_i;
    n.sda_s = s.sda_m;
    n.sda_d = s.sda_s;
    rise = s.scl_s & ~s.scl_d;
    fall = ~s.scl_s & s.scl_d;
    if (s.scl_s && s.scl_d && !s.sda_s && s.sda_d)
    begin
      n.phase = ADDR;
      n.cnt = 4'h0;
      n.oe = 1'b0;
      n.evt.start = 1'b1;
    end
    else if (s.scl_s && s.scl_d && s.sda_s && !s.sda_d)
    begin
      n.phase = IDLE;
      n.oe = 1'b0;
      n.evt.stop = 1'b1;
    end
    else
    begin
      unique case (s.phase)
        IDLE: ;
        ADDR, RX:
          if (rise && s.cnt != 4'h8)
          begin
            n.sh = {s.sh[6:0], s.sda_s};
            n.cnt = s.cnt + 4'h1;
          end
          else if (fall && s.cnt == 4'h8)
          begin
            if (s.phase == RX)
            begin
              n.oe = 1'b1;
              n.phase = ACK_RX;
              n.evt.rx_valid = 1'b1;
              n.evt.rx_byte = s.sh;
            end
            else if (s.sh[7:1] == own_addr_i)
            begin
              n.oe = 1'b1;
              n.rw = s.sh[0];
              n.phase = ACK_ADDR;
              n.evt.rd_go = s.sh[0];
            end
            else
              n.phase = IDLE;
          end
        ACK_ADDR, ACK_RX:
          if (fall)
          begin
            n.cnt = 4'h0;
            if (s.phase == ACK_ADDR && s.rw)
            begin
              n.sh = tx_byte_i;
              n.oe = ~tx_byte_i[7];
              n.phase = TX;
            end
            else
            begin
              n.oe = 1'b0;
              n.phase = RX;
            end
          end
        TX:
          if (rise && s.cnt != 4'h8)
            n.cnt = s.cnt + 4'h1;
          else if (fall && s.cnt == 4'h8)
          begin
            n.oe = 1'b0;
            n.phase = TX_ACK;
          end
          else if (fall)
            n.oe = ~s.sh[3'h7 - s.cnt[2:0]];
        TX_ACK:
          if (rise && s.sda_s)
            n.phase = IDLE;
          else if (rise)
            n.evt.tx_next = 1'b1;
          else if (fall)
          begin
            n.sh = tx_byte_i;
            n.oe = ~tx_byte_i[7];
            n.cnt = 4'h0;
            n.phase = TX;
          end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      s <= TGT_RST;
    else
      s <= n;
  end

  assign sda_oe_o = s.oe;
  assign evt_o = s.evt;
endmodule

// ---- src/input_voltage_limit_monitor.sv ----
// Input-voltage limit monitor: limits, sticky flags, event record, bus.
// Assumes samples arrive on clk_i; bus and strap pins come from outside.
`timescale 1ns/1ps
module input_voltage_limit_monitor
  import vmon_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_US * CLK_MHZ  // Record tick period
)
(
  input wire logic clk_i,  // 125 MHz clock
  input wire logic srst_i,  // Synchronous reset
  input wire logic scl_i,  // Bus clock pin
  input wire logic sda_i,  // Bus data pin level
  output logic sda_o,  // Data drive level, always low
  output logic sda_oe_o,  // Data pin pulled low
  input wire logic [1:0] addr_select_pin_0_i,  // Strap state, pin 0
  input wire logic [1:0] addr_select_pin_1_i,  // Strap state, pin 1
  input wire logic [6:0] nvm_addr_i,  // Saved user address
  output logic nvm_store_o,  // Save user address pulse
  output logic [6:0] nvm_addr_o,  // User address to save
  input wire logic [7:0] vin_sample_i,  // Input-voltage sample
  input wire logic vin_sample_valid_i,  // Sample strobe
  input wire logic record_reset_i,  // Enable, off-on or retry pulse
  output logic switch_on_o,  // Output switch enable
  output logic power_good_out_o,  // Power-good pin level
  output logic alert_out_n_o  // Alert, active low
);
  localparam int TICK_W = $clog2(TICK_CYCLES);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  localparam logic [8:0] HYST = 9'(HYST_CODES);

  if (TICK_CYCLES < 2)
  begin : g_check
    $error("TICK_CYCLES must be at least 2");
  end

  typedef struct packed {
    logic [10:0] strap_meta;
    logic [10:0] strap_sync;
    logic [1:0] settle;
    logic strap_done;
    logic both_open;
    logic [6:0] strap_addr;
    logic [6:0] user_addr;
    logic [7:0] ov_warn_lim;
    logic [7:0] uv_warn_lim;
    logic [7:0] uv_fault_lim;
    logic [7:0] alert_mask;
    logic [7:0] pin_cfg;
    logic [7:0] write_lock;
    logic [2:0] idx;
    logic reading;
    logic [2:0] tidx;
    logic [7:0] cmd;
    logic [7:0] d0;
    logic [7:0] d1;
    logic [7:0] tx_byte;
    logic cond_uvw;
    logic cond_ovw;
    logic fault_live;
    logic flag_uvw;
    logic flag_ovw;
    logic flag_uvf;
    logic [6:0] slot_used;
    logic [6:0][7:0] slot;
    logic [2:0] ptr;
    logic expired;
    logic [3:0] tick;
    logic [TICK_W-1:0] div;
    logic switch_on;
    logic pg;
    logic alert_n;
    logic nvm_store;
  } mon_s;

  localparam mon_s MON_RST = '{default: '0, strap_addr: DEFAULT_ADDR,
                               ov_warn_lim: OV_WARN_RST, uv_warn_lim: UV_WARN_RST,
                               uv_fault_lim: UV_FAULT_RST, pin_cfg: PIN_CFG_RST,
                               write_lock: UNLOCKED, switch_on: 1'b1, pg: 1'b1,
                               alert_n: 1'b1};
  mon_s s;
  mon_s n;
  smb_evt_s evt;
  logic [6:0] own_addr;
  logic do_clear;
  logic unlocked;
  logic log_ev;
  logic [3:0] ev_id;
  logic any_flag;
  logic [7:0] st_byte;
  logic [7:0] st_hi;
  logic [7:0] st_in;
  logic [15:0] rd_word;

  // --------------------------------------------------------------
  // Bus target
  // --------------------------------------------------------------
  assign own_addr = s.both_open ? s.user_addr : s.strap_addr;

  smb_target u_target (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .own_addr_i(own_addr),
    .tx_byte_i(s.tx_byte),
    .sda_oe_o(sda_oe_o),
    .evt_o(evt)
  );

  always_comb
  begin
    n = s;
    n.nvm_store = 1'b0;
    do_clear = 1'b0;
    unlocked = (s.write_lock == UNLOCKED);
    // ------------------------------------------------------------
    // Straps, caught once after the synchronisers have settled
    // ------------------------------------------------------------
    n.strap_meta = {nvm_addr_i, addr_select_pin_1_i, addr_select_pin_0_i};
    n.strap_sync = s.strap_meta;
    if (!s.strap_done)
    begin
      n.settle = s.settle + 2'h1;
      if (s.settle == 2'(STRAP_SETTLE))
      begin
        n.strap_done = 1'b1;
        n.user_addr = s.strap_sync[10:4];
        n.both_open = (s.strap_sync[3:2] == PIN_OPEN) && (s.strap_sync[1:0] == PIN_OPEN);
        n.strap_addr = DEFAULT_ADDR | {3'h0, s.strap_sync[3:0]};
      end
    end
    // ------------------------------------------------------------
    // Command framing
    // ------------------------------------------------------------
    if (evt.start)
    begin
      n.idx = 3'h0;
      n.reading = 1'b0;
    end
    if (evt.rx_valid)
    begin
      if (s.idx == 3'h0)
        n.cmd = evt.rx_byte;
      else if (s.idx == 3'h1)
        n.d0 = evt.rx_byte;
      else
        n.d1 = evt.rx_byte;
      if (s.idx != 3'h4)
        n.idx = s.idx + 3'h1;
    end
    if (evt.rd_go)
    begin
      n.reading = 1'b1;
      n.tidx = 3'h0;
    end
    if (evt.tx_next && s.tidx != 3'h7)
      n.tidx = s.tidx + 3'h1;
    // Writes take effect at stop so a truncated frame changes nothing
    if (evt.stop && !s.reading)
    begin
      case (s.idx)
        3'h1:
          if (s.cmd == CMD_CLEAR_FAULTS)
            do_clear = 1'b1;
          else if (s.cmd == CMD_STORE_ADDR)
            n.nvm_store = 1'b1;
        3'h2:
          if (s.cmd == CMD_USER_ADDR && unlocked)
            n.user_addr = s.d0[6:0];
          else if (s.cmd == CMD_ALERT_MASK)
            n.alert_mask = s.d0;
          else if (s.cmd == CMD_PIN_CONFIG)
            n.pin_cfg = s.d0;
          else if (s.cmd == CMD_WRITE_UNLOCK)
            n.write_lock = s.d0;
        3'h3:
          // High byte above the range is refused
          if (unlocked && s.d1 == 8'h00)
          begin
            if (s.cmd == CMD_OV_WARN)
              n.ov_warn_lim = s.d0;
            else if (s.cmd == CMD_UV_WARN)
              n.uv_warn_lim = s.d0;
            else if (s.cmd == CMD_UV_FAULT)
              n.uv_fault_lim = s.d0;
          end
        default: ;
      endcase
    end
    // ------------------------------------------------------------
    // Limit checks
    // ------------------------------------------------------------
    if (vin_sample_valid_i)
    begin
      n.cond_uvw = vin_sample_i < s.uv_warn_lim;
      n.cond_ovw = vin_sample_i > s.ov_warn_lim;
      if (!s.fault_live)
        n.fault_live = vin_sample_i < s.uv_fault_lim;
      else
        n.fault_live = {1'b0, vin_sample_i} <= {1'b0, s.uv_fault_lim} + HYST;
    end
    // A live condition holds its flag through a clear
    n.flag_uvw = n.cond_uvw | (s.flag_uvw & ~do_clear);
    n.flag_ovw = n.cond_ovw | (s.flag_ovw & ~do_clear);
    n.flag_uvf = n.fault_live | (s.flag_uvf & ~do_clear);
    n.switch_on = ~n.fault_live;
    n.pg = n.pin_cfg[CFG_PG] & ~n.fault_live;
    n.alert_n = ~(n.pin_cfg[CFG_ALERT]
                  & (((n.flag_uvw | n.flag_ovw) & ~n.alert_mask[MASK_IN])
                     | (n.flag_uvf & ~(n.alert_mask[MASK_IN] & n.alert_mask[MASK_PG]
                                       & n.alert_mask[MASK_OUT]))));
    // ------------------------------------------------------------
    // Event record
    // ------------------------------------------------------------
    // Both warnings in one sample only happen with crossed limits
    log_ev = (n.cond_uvw & ~s.cond_uvw) | (n.cond_ovw & ~s.cond_ovw);
    ev_id = (n.cond_uvw & ~s.cond_uvw) ? EV_UV_WARN : EV_OV_WARN;
    if (s.div == TICK_LAST)
    begin
      n.div = '0;
      n.tick = s.tick + 4'h1;
      if (s.tick == 4'hF)
        n.expired = 1'b1;
    end
    else
      n.div = s.div + TICK_W'(1);
    if (do_clear || record_reset_i)
    begin
      n.slot_used = '0;
      n.slot = '0;
      n.ptr = 3'h0;
      n.expired = 1'b0;
      n.tick = 4'h0;
      n.div = '0;
    end
    else if (log_ev)
    begin
      n.tick = 4'h0;
      n.expired = 1'b0;
      n.div = '0;
      if (!s.slot_used[s.ptr])
      begin
        n.slot[s.ptr] = {ev_id, s.tick};
        n.slot_used[s.ptr] = 1'b1;
        n.ptr = (s.ptr < PTR_LAST) ? s.ptr + 3'h1 : 3'h0;
      end
    end
    // ------------------------------------------------------------
    // Status and read data
    // ------------------------------------------------------------
    any_flag = s.flag_uvw | s.flag_ovw | s.flag_uvf;
    st_byte = 8'h00;
    st_byte[SB_SWITCH_OFF] = s.flag_uvf;
    st_byte[SB_UV_FAULT] = s.flag_uvf;
    st_byte[SB_CATCH_ALL] = any_flag;
    st_hi = 8'h00;
    st_hi[SW_OUT] = s.flag_uvf;
    st_hi[SW_INPUT] = any_flag;
    st_hi[SW_PG_LOW] = s.flag_uvf;
    st_hi[SW_CATCH_ALL] = s.flag_uvf;
    st_in = 8'h00;
    st_in[SI_OV_WARN] = s.flag_ovw;
    st_in[SI_UV_WARN] = s.flag_uvw;
    st_in[SI_UV_FAULT] = s.flag_uvf;
    rd_word = 16'hFFFF;
    case (s.cmd)
      CMD_OV_WARN: rd_word = {8'h00, s.ov_warn_lim};
      CMD_UV_WARN: rd_word = {8'h00, s.uv_warn_lim};
      CMD_UV_FAULT: rd_word = {8'h00, s.uv_fault_lim};
      CMD_STATUS_BYTE: rd_word[7:0] = st_byte;
      CMD_STATUS_WORD: rd_word = {st_hi, st_byte};
      CMD_STATUS_OUT: rd_word[7:0] = {2'h0, s.flag_uvf, 5'h00};
      CMD_STATUS_INPUT: rd_word[7:0] = st_in;
      CMD_MAKER_TWO: rd_word[7:0] = {3'h0, s.flag_uvf, 4'h0};
      CMD_ALERT_MASK: rd_word[7:0] = s.alert_mask;
      CMD_PIN_CONFIG: rd_word[7:0] = s.pin_cfg;
      CMD_WRITE_UNLOCK: rd_word[7:0] = s.write_lock;
      CMD_EVENT_TIMER: rd_word[7:0] = {s.ptr, s.expired, s.tick};
      CMD_USER_ADDR: rd_word[7:0] = {1'b0, s.user_addr};
      default: ;
    endcase
    if (s.cmd == CMD_EVENT_READ)
      n.tx_byte = (s.tidx == 3'h7) ? 8'hFF : s.slot[s.tidx];
    else if (s.tidx == 3'h0)
      n.tx_byte = rd_word[7:0];
    else if (s.tidx == 3'h1)
      n.tx_byte = rd_word[15:8];
    else
      n.tx_byte = 8'hFF;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      s <= MON_RST;
    else
      s <= n;
  end

  assign sda_o = 1'b0;
  assign nvm_store_o = s.nvm_store;
  assign nvm_addr_o = s.user_addr;
  assign switch_on_o = s.switch_on;
  assign power_good_out_o = s.pg;
  assign alert_out_n_o = s.alert_n;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  chk_uv_warn_set: assert property (
    vin_sample_valid_i && vin_sample_i < s.uv_warn_lim |=> s.flag_uvw && s.cond_uvw)
    else $error("undervoltage warning not flagged");
  chk_uv_warn_hold: assert property (
    s.flag_uvw && s.cond_uvw && !vin_sample_valid_i |=> s.flag_uvw)
    else $error("undervoltage warning cleared while input low");
  chk_ov_warn_set: assert property (
    vin_sample_valid_i && vin_sample_i > s.ov_warn_lim |=> s.flag_ovw && s.cond_ovw)
    else $error("overvoltage warning not flagged");
  chk_fault_off: assert property (
    vin_sample_valid_i && vin_sample_i < s.uv_fault_lim |=> !switch_on_o && s.flag_uvf)
    else $error("fault did not switch output off");
  chk_fault_hyst: assert property (
    s.fault_live && vin_sample_valid_i
    && {1'b0, vin_sample_i} <= {1'b0, s.uv_fault_lim} + HYST |=> !switch_on_o)
    else $error("fault released inside hysteresis");
  chk_fault_sticky: assert property (
    s.flag_uvf && !do_clear |=> s.flag_uvf)
    else $error("fault flag lost without clear");
  chk_ptr_step: assert property (
    log_ev && !do_clear && !record_reset_i && !s.slot_used[s.ptr]
    |=> s.ptr == (($past(s.ptr) == PTR_LAST) ? 3'h0 : $past(s.ptr) + 3'h1))
    else $error("record pointer stepped wrongly");
  chk_ptr_full: assert property (
    log_ev && !do_clear && !record_reset_i && s.slot_used[s.ptr] |=> $stable(s.ptr))
    else $error("record pointer moved with no free entry");
  chk_record_reset: assert property (
    do_clear || record_reset_i |=> s.ptr == 3'h0 && s.slot_used == 7'h00 && s.tick == 4'h0)
    else $error("record not reset");
  chk_alert_gate: assert property (
    !alert_out_n_o |-> s.pin_cfg[CFG_ALERT] && (s.flag_uvw || s.flag_ovw || s.flag_uvf))
    else $error("alert without enabled pin or flag");
  chk_pg_drop: assert property (
    !switch_on_o |-> !power_good_out_o)
    else $error("power good high during fault");
  chk_addr_open: assert property (
    s.both_open |-> own_addr == s.user_addr)
    else $error("open straps not using user address");

  cov_uv_logged: cover property (log_ev && ev_id == EV_UV_WARN && !s.slot_used[s.ptr]);
  cov_ptr_wrap: cover property (log_ev && s.ptr == PTR_LAST);
  cov_fault_cycle: cover property (!switch_on_o ##[1:1000] switch_on_o);
  cov_read: cover property (evt.rd_go);
endmodule

// ---- tb/smb_host_model.sv ----
// Bus host model: runs the bus clock, pulls data low, reads bytes back.
// Assumes each call starts just after a falling clk_i edge of the bench.
`timescale 1ns/1ps
module smb_host_model
(
  input wire logic dev_oe_i,  // Device pulls data low
  output logic scl_o,  // Bus clock, idle high
  output logic sda_o,  // Resolved data, pulled up
  output logic addr_ack_o,  // Address byte acked
  output logic [7:0] rx_o,  // Byte read
  output logic rx_stb_o  // Byte read pulse
);
  logic pull = 1'b0;
  logic smp;
  assign sda_o = ~(pull | dev_oe_i);
  initial {scl_o, rx_stb_o} = 2'b10;
  // Data moves 24 ns into the low phase, after the device lets go
  task automatic cyc(input logic p1, input logic p2, input logic fall);
    #24 pull = p1;
    #16 scl_o = 1'b1;
    #24 smp = sda_o;
    pull = p2;
    #16 scl_o = ~fall;
  endtask
  task automatic byt(input logic [7:0] v, input logic p);
    for (int i = 7; i >= 0; i--)
    begin
      cyc(~v[i], ~v[i], 1'b1);
      rx_o[i] = smp;
    end
    cyc(p, p, 1'b1);
  endtask
  task automatic xact(input logic [6:0] a, input logic [7:0] c, input int n,
                      input logic [15:0] d, input logic r);
    cyc(1'b1, 1'b1, 1'b1);
    byt({a, 1'b0}, 1'b0);
    addr_ack_o = ~smp;
    byt(c, 1'b0);
    if (r)
      cyc(1'b0, 1'b1, 1'b1);
    if (r)
      byt({a, 1'b1}, 1'b0);
    for (int i = 0; i < n; i++)
    begin
      byt(r ? 8'hFF : d[8*i+:8], r && i < n - 1);
      rx_stb_o = r;
      #8 rx_stb_o = 1'b0;
    end
    cyc(1'b1, 1'b0, 1'b0);
  endtask
endmodule

// ---- tb/test_input_voltage_limit_monitor.sv ----
// Bench of the input-voltage limit monitor: bus traffic, samples, checks.
// Assumes the host model runs the bus; address straps start open, tied low at the end.
`timescale 1ns/1ps
module test_input_voltage_limit_monitor
  import vmon_pkg::*;
;
  logic clk_i = 1'b0;
  logic srst_i, scl, sda, oe, ack, stb, vld, rr, st, sw, pg, alert_n;
  logic [7:0] vin, rx, r;
  logic [6:0] nvm, dev, na, sv;
  logic [15:0] e;
  logic [1:0] pins = 2'h2;
  logic [15:0] q[$];
  logic [23:0] alt[2] = '{{CMD_ALERT_MASK, 16'h2000}, {CMD_PIN_CONFIG, 16'h0103}};
  int failures = 0;
  int compares = 0;
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i)
    if (st === 1'b1)
      sv <= na;
  input_voltage_limit_monitor #(.TICK_CYCLES(8)) input_voltage_limit_monitor_inst (.clk_i,
    .srst_i, .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(oe), .addr_select_pin_0_i(pins),
    .addr_select_pin_1_i(pins), .nvm_addr_i(nvm), .nvm_store_o(st), .nvm_addr_o(na),
    .vin_sample_i(vin), .vin_sample_valid_i(vld), .record_reset_i(rr), .switch_on_o(sw),
    .power_good_out_o(pg), .alert_out_n_o(alert_n));
  smb_host_model smb_host_model_inst (.dev_oe_i(oe), .scl_o(scl), .sda_o(sda),
    .addr_ack_o(ack), .rx_o(rx), .rx_stb_o(stb));
  task automatic chk(input string s, input logic [7:0] g, input logic [7:0] x);
    compares++;
    if (g !== x)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", s, x, g);
    end
  endtask
  // Queue entries hold {mask, masked value}: timer ticks are left out
  always @(posedge stb)
  begin
    e = q.pop_front();
    chk("read", rx & e[15:8], e[7:0]);
  end
  task automatic bus(input logic [7:0] c, input int n, input logic [15:0] d, input logic f);
    @(negedge clk_i);
    smb_host_model_inst.xact(dev, c, n, d, f);
    repeat (8) @(negedge clk_i);
  endtask
  task automatic rd(input logic [7:0] c, input int n, input logic [15:0] d, input logic [15:0] m);
    for (int i = 0; i < n; i++)
      q.push_back({m[8*i+:8], d[8*i+:8] & m[8*i+:8]});
    bus(c, n, d, 1'b1);
  endtask
  task automatic feed(input logic [7:0] v, input logic [2:0] x, input logic [2:0] m);
    @(negedge clk_i);
    vin = v;
    vld = 1'b1;
    @(negedge clk_i);
    vld = 1'b0;
    @(negedge clk_i);
    chk("pins", {5'h0, {sw, pg, alert_n} & m}, {5'h0, x & m});
  endtask
  task automatic clean();
    feed(8'hA0, 3'b000, 3'b000);
    bus(CMD_CLEAR_FAULTS, 0, 16'h0000, 1'b0);
    feed(8'hA0, 3'b111, 3'b111);
  endtask
  task automatic report_and_stop();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    {srst_i, vld, rr, vin, nvm, dev} = {3'b100, 8'hA0, 7'h2A, 7'h2A};
    r = 8'($urandom(32'hFB5C8D4F));
    repeat (20) @(negedge clk_i);
    srst_i = 1'b0;
    repeat (20) @(negedge clk_i);
    rd(CMD_OV_WARN, 2, 16'h00A5, 16'hFFFF);
    rd(CMD_UV_WARN, 2, 16'h0095, 16'hFFFF);
    rd(CMD_UV_FAULT, 2, 16'h008D, 16'hFFFF);
    bus(CMD_WRITE_UNLOCK, 1, 16'h0000, 1'b0);
    r = 8'($urandom_range(255));
    bus(CMD_OV_WARN, 2, {8'h00, r}, 1'b0);
    rd(CMD_OV_WARN, 2, {8'h00, r}, 16'hFFFF);
    bus(CMD_OV_WARN, 2, 16'h00A5, 1'b0);
    $display("limits done");
    feed(8'h90, 3'b110, 3'b111);
    rd(CMD_STATUS_WORD, 2, 16'h2001, 16'hA849);
    rd(CMD_STATUS_INPUT, 1, 16'h0020, 16'h0070);
    rd(CMD_EVENT_TIMER, 1, 16'h0020, 16'h00E0);
    rd(CMD_EVENT_READ, 2, 16'h0010, 16'hFFF0);
    bus(CMD_CLEAR_FAULTS, 0, 16'h0000, 1'b0);
    feed(8'h90, 3'b110, 3'b111);
    feed(8'hA0, 3'b110, 3'b111);
    clean();
    rd(CMD_EVENT_TIMER, 1, 16'h0000, 16'h00E0);
    $display("undervoltage warning done");
    feed(8'h80, 3'b000, 3'b111);
    rd(CMD_STATUS_WORD, 2, 16'hAA49, 16'hAA49);
    rd(CMD_STATUS_OUT, 1, 16'h0020, 16'h0020);
    rd(CMD_STATUS_INPUT, 1, 16'h0010, 16'h0010);
    rd(CMD_MAKER_TWO, 1, 16'h0010, 16'h0010);
    feed(8'h91, 3'b000, 3'b101);
    feed(8'h92, 3'b100, 3'b101);
    feed(8'hA0, 3'b100, 3'b101);
    clean();
    $display("undervoltage fault done");
    feed(8'hB0, 3'b110, 3'b111);
    rd(CMD_STATUS_WORD, 2, 16'h2001, 16'hA849);
    rd(CMD_STATUS_INPUT, 1, 16'h0040, 16'h0070);
    rd(CMD_EVENT_TIMER, 1, 16'h0020, 16'h00E0);
    rd(CMD_EVENT_READ, 1, 16'h0020, 16'h00F0);
    @(negedge clk_i);
    rr = 1'b1;
    @(negedge clk_i);
    rr = 1'b0;
    rd(CMD_EVENT_TIMER, 1, 16'h0000, 16'h00E0);
    feed(8'hA0, 3'b110, 3'b111);
    clean();
    $display("overvoltage warning done");
    for (int i = 0; i < 8; i++)
    begin
      feed(8'h90, 3'b000, 3'b000);
      feed(8'hA0, 3'b000, 3'b000);
      rd(CMD_EVENT_TIMER, 1, {8'h00, 3'((i < 6) ? i + 1 : 0), 5'h00}, 16'h00E0);
    end
    clean();
    $display("record pointer done");
    for (int i = 0; i < 2; i++)
    begin
      bus(alt[i][23:16], 1, {8'h00, alt[i][15:8]}, 1'b0);
      feed(8'h90, 3'b111, 3'b001);
      bus(alt[i][23:16], 1, {8'h00, alt[i][7:0]}, 1'b0);
      clean();
    end
    $display("alert gating done");
    bus(CMD_USER_ADDR, 1, 16'h0033, 1'b0);
    dev = 7'h33;
    rd(CMD_USER_ADDR, 1, 16'h0033, 16'h00FF);
    bus(CMD_STORE_ADDR, 0, 16'h0000, 1'b0);
    chk("saved address", {1'b0, sv}, 8'h33);
    nvm = sv;
    srst_i = 1'b1;
    repeat (20) @(negedge clk_i);
    srst_i = 1'b0;
    repeat (20) @(negedge clk_i);
    rd(CMD_USER_ADDR, 1, 16'h0033, 16'h00FF);
    dev = DEFAULT_ADDR;
    bus(CMD_CLEAR_FAULTS, 0, 16'h0000, 1'b0);
    chk("default ack", {7'h00, ack}, 8'h00);
    // Straps tied low: the default address must answer again
    pins = 2'h0;
    srst_i = 1'b1;
    repeat (20) @(negedge clk_i);
    srst_i = 1'b0;
    repeat (20) @(negedge clk_i);
    bus(CMD_CLEAR_FAULTS, 0, 16'h0000, 1'b0);
    chk("strap ack", {7'h00, ack}, 8'h01);
    chk("pending reads", 8'(q.size()), 8'h00);
    $display("address done");
    report_and_stop();
  end
endmodule
